/* File: design/rate_seq_defines.svh */
// register offsets, write values and sequence sizes for the lane rate reconfiguration host
`ifndef RATE_SEQ_DEFINES_SVH
`define RATE_SEQ_DEFINES_SVH

// ------------------------------------------------------------
// register offsets of the device
// ------------------------------------------------------------
`define OFS_LANE0_CONFIG       32'h000132B0
`define OFS_LANE1_CONFIG       32'h000132B4
`define OFS_LANE2_CONFIG       32'h000132B8
`define OFS_LANE3_CONFIG       32'h000132BC
`define OFS_PHY_GLOBAL_CONFIG  32'h000132C0
`define OFS_PLL_MULTIPLIER     32'h000132C4
`define OFS_MAC_CONTROL        32'h000132C8
`define LANE_CONFIG_STRIDE     32'h00000004

// ------------------------------------------------------------
// write values
// ------------------------------------------------------------
`define VAL_MAC_SOFT_RESET     32'h7FFF0012
`define VAL_MAC_RELEASE        32'h7FFF0002
`define VAL_GBL_OVERRIDE       32'hCA060084
`define VAL_GBL_PLL_OFF        32'hCA060004
`define VAL_GBL_CLK_GATE       32'hCA060044
`define VAL_GBL_MULT_GATED     32'hCA060045
`define VAL_GBL_CLK_RUN        32'hCA060005
`define VAL_GBL_LANE_RST_LOW   32'h4A060005
`define VAL_GBL_PLL_ON         32'hCA060085
`define VAL_PLL_MULT_X25       32'h002C0545
`define VAL_LANE_RX_OFF        32'h203CA513
`define VAL_LANE_RXPLL_OFF     32'h203C2513
`define VAL_LANE_TX_OFF        32'h200C2513
`define VAL_LANE_TX_ON         32'h203C2513
`define VAL_LANE_RXPLL_ON      32'h203CA513
`define VAL_LANE_RX_ON         32'h203CE513

// ------------------------------------------------------------
// sequence sizes and timing
// ------------------------------------------------------------
`define NUM_LANES              4
`define NUM_STEPS              35
`define STEP_IDX_W             6
`define RESP_TIMEOUT_NS        100000
`define CLK_PERIOD_NS          10
`define RESP_TIMEOUT_CYC       (`RESP_TIMEOUT_NS / `CLK_PERIOD_NS)
`define TIMER_W                20

`endif

/* File: design/rate_seq_pkg.sv */
// types shared by the lane rate reconfiguration host
package rate_seq_pkg;

  typedef enum {
    SEQ_IDLE,
    SEQ_ISSUE,
    SEQ_WAIT,
    SEQ_DONE,
    SEQ_FAIL
  } seq_state_t;

  typedef struct packed {
    logic [31:0] offset;
    logic [31:0] data;
  } reg_write_t;

endpackage

/* File: design/step_if.sv */
// step index and the write that it selects, shared by sequencer and step table
`timescale 1ns/1ps
interface step_if;
  logic [5:0]               idx;
  rate_seq_pkg::reg_write_t wr;

  modport seq (output idx, input wr);
  modport rom (input idx, output wr);
endinterface

/* File: design/step_table.sv */
// constant table of the ordered maintenance writes
`timescale 1ns/1ps
`include "rate_seq_defines.svh"
module step_table (
  step_if.rom st
);

  // ------------------------------------------------------------
  // lane pass helper: four lanes with one value, in lane order
  // ------------------------------------------------------------
  function automatic rate_seq_pkg::reg_write_t lane_wr(input logic [5:0] i,
                                                       input logic [5:0] base,
                                                       input logic [31:0] val);
    rate_seq_pkg::reg_write_t w;
    logic [5:0]               l;
    l = 6'(i - base);
    w.offset = `OFS_LANE0_CONFIG + 32'(l) * `LANE_CONFIG_STRIDE;
    w.data   = val;
    return w;
  endfunction

  always_comb begin
    st.wr = '{offset: `OFS_MAC_CONTROL, data: `VAL_MAC_RELEASE};
    if (st.idx == 6'h00) begin
      st.wr = '{offset: `OFS_MAC_CONTROL, data: `VAL_MAC_SOFT_RESET};
    end else if (st.idx == 6'h01) begin
      st.wr = '{offset: `OFS_PHY_GLOBAL_CONFIG, data: `VAL_GBL_OVERRIDE};
    end else if (st.idx < 6'h06) begin
      st.wr = lane_wr(st.idx, 6'h02, `VAL_LANE_RX_OFF);
    end else if (st.idx < 6'h0A) begin
      st.wr = lane_wr(st.idx, 6'h06, `VAL_LANE_RXPLL_OFF);
    end else if (st.idx < 6'h0E) begin
      st.wr = lane_wr(st.idx, 6'h0A, `VAL_LANE_TX_OFF);
    end else if (st.idx == 6'h0E) begin
      st.wr = '{offset: `OFS_PHY_GLOBAL_CONFIG, data: `VAL_GBL_PLL_OFF};
    end else if (st.idx == 6'h0F) begin
      st.wr = '{offset: `OFS_PHY_GLOBAL_CONFIG, data: `VAL_GBL_CLK_GATE};
    end else if (st.idx == 6'h10) begin
      st.wr = '{offset: `OFS_PLL_MULTIPLIER, data: `VAL_PLL_MULT_X25};
    end else if (st.idx == 6'h11) begin
      st.wr = '{offset: `OFS_PHY_GLOBAL_CONFIG, data: `VAL_GBL_MULT_GATED};
    end else if (st.idx == 6'h12) begin
      st.wr = '{offset: `OFS_PHY_GLOBAL_CONFIG, data: `VAL_GBL_CLK_RUN};
    end else if (st.idx == 6'h13) begin
      st.wr = '{offset: `OFS_PHY_GLOBAL_CONFIG, data: `VAL_GBL_LANE_RST_LOW};
    end else if (st.idx == 6'h14) begin
      st.wr = '{offset: `OFS_PHY_GLOBAL_CONFIG, data: `VAL_GBL_CLK_RUN};
    end else if (st.idx == 6'h15) begin
      st.wr = '{offset: `OFS_PHY_GLOBAL_CONFIG, data: `VAL_GBL_PLL_ON};
    end else if (st.idx < 6'h1A) begin
      st.wr = lane_wr(st.idx, 6'h16, `VAL_LANE_TX_ON);
    end else if (st.idx < 6'h1E) begin
      st.wr = lane_wr(st.idx, 6'h1A, `VAL_LANE_RXPLL_ON);
    end else if (st.idx < 6'h22) begin
      st.wr = lane_wr(st.idx, 6'h1E, `VAL_LANE_RX_ON);
    end
  end

endmodule // step_table

/* File: design/resp_timer.sv */
// watchdog that bounds the wait for one write response
`timescale 1ns/1ps
`include "rate_seq_defines.svh"
module resp_timer #(
  parameter logic [19:0] LIMIT = 20'(`RESP_TIMEOUT_CYC)
) (
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  input  wire logic run_i,
  output logic      expired_o
);

  logic [`TIMER_W-1:0] count_reg;

  // restarts whenever run drops, so each write gets a full budget
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i || !run_i) begin
      count_reg <= '0;
    end else if (count_reg != LIMIT) begin
      count_reg <= count_reg + 20'h00001;
    end
  end

  assign expired_o = run_i && (count_reg == LIMIT);

endmodule // resp_timer

/* File: design/serdes_rate_reconfig_seq.sv */
// host sequencer that retunes one port's lanes to the higher rate by maintenance writes
`timescale 1ns/1ps
`include "rate_seq_defines.svh"
module serdes_rate_reconfig_seq #(
  parameter logic [19:0] RESP_TIMEOUT = 20'(`RESP_TIMEOUT_CYC)
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  // user side
  input  wire logic        start_i,
  input  wire logic        link_ready_i,
  output logic             busy_o,
  output logic             done_o,
  output logic             error_o,
  output logic [5:0]       step_o,
  // maintenance write port toward the link
  output logic             mnt_wr_valid_o,
  input  wire logic        mnt_wr_ready_i,
  output logic [31:0]      mnt_wr_offset_o,
  output logic [31:0]      mnt_wr_data_o,
  input  wire logic        mnt_resp_valid_i,
  input  wire logic        mnt_resp_error_i
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  rate_seq_pkg::seq_state_t state_reg;
  logic [5:0]               idx_reg;
  logic [31:0]              offset_reg;
  logic [31:0]              data_reg;
  logic                     timed_out;
  logic                     last_step;
  logic                     restart;
  logic                     advance;
  logic [5:0]               idx_ahead;

  step_if st ();

  step_table u_table (
    .st (st.rom)
  );

  resp_timer #(
    .LIMIT (RESP_TIMEOUT)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .run_i     (state_reg == rate_seq_pkg::SEQ_WAIT),
    .expired_o (timed_out)
  );

  assign last_step = (idx_reg == 6'(`NUM_STEPS - 1));
  assign restart   = (state_reg != rate_seq_pkg::SEQ_ISSUE)
                  && (state_reg != rate_seq_pkg::SEQ_WAIT) && start_i && link_ready_i;
  assign advance   = (state_reg == rate_seq_pkg::SEQ_WAIT) && mnt_resp_valid_i
                  && !mnt_resp_error_i && !last_step;
  // table is read one step ahead so that the write fields leave from flip-flops
  assign idx_ahead = restart ? 6'h00 : (advance ? idx_reg + 6'h01 : idx_reg);
  assign st.idx    = idx_ahead;

  // ------------------------------------------------------------
  // sequence control
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_reg <= rate_seq_pkg::SEQ_IDLE;
    end else begin
      unique case (state_reg)
        rate_seq_pkg::SEQ_IDLE, rate_seq_pkg::SEQ_DONE, rate_seq_pkg::SEQ_FAIL: begin
          if (start_i && link_ready_i) begin
            state_reg <= rate_seq_pkg::SEQ_ISSUE;
          end
        end
        rate_seq_pkg::SEQ_ISSUE: begin
          if (mnt_wr_ready_i) begin
            state_reg <= rate_seq_pkg::SEQ_WAIT;
          end
        end
        rate_seq_pkg::SEQ_WAIT: begin
          // an error or lost response stops the sequence: resuming mid-way is unsafe
          if (mnt_resp_valid_i && mnt_resp_error_i) begin
            state_reg <= rate_seq_pkg::SEQ_FAIL;
          end else if (mnt_resp_valid_i) begin
            state_reg <= last_step ? rate_seq_pkg::SEQ_DONE
                                   : rate_seq_pkg::SEQ_ISSUE;
          end else if (timed_out) begin
            state_reg <= rate_seq_pkg::SEQ_FAIL;
          end
        end
      endcase
    end
  end

  // step index advances only on a good response
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      idx_reg <= 6'h00;
    end else if (restart) begin
      idx_reg <= 6'h00;
    end else if (advance) begin
      idx_reg <= idx_reg + 6'h01;
    end
  end

  // ------------------------------------------------------------
  // write data registers
  // ------------------------------------------------------------
  // always holds the table entry of the index in use, so it stands through ISSUE
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      offset_reg <= `OFS_MAC_CONTROL;
      data_reg   <= `VAL_MAC_SOFT_RESET;
    end else begin
      offset_reg <= st.wr.offset;
      data_reg   <= st.wr.data;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // valid is combinational so the write goes out in the ISSUE cycle itself
  assign mnt_wr_valid_o  = (state_reg == rate_seq_pkg::SEQ_ISSUE);
  assign mnt_wr_offset_o = offset_reg;
  assign mnt_wr_data_o   = data_reg;
  assign busy_o  = (state_reg == rate_seq_pkg::SEQ_ISSUE)
                || (state_reg == rate_seq_pkg::SEQ_WAIT);
  assign done_o  = (state_reg == rate_seq_pkg::SEQ_DONE);
  assign error_o = (state_reg == rate_seq_pkg::SEQ_FAIL);
  assign step_o  = idx_reg;

endmodule // serdes_rate_reconfig_seq

/* File: testbench/rate_seq_asserts.sv */
// concurrent checks on the rate reconfiguration host ports
`timescale 1ns/1ps
module rate_seq_asserts (
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  input wire logic        start_i,
  input wire logic        link_ready_i,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        error_o,
  input wire logic [5:0]  step_o,
  input wire logic        mnt_wr_valid_o,
  input wire logic        mnt_wr_ready_i,
  input wire logic [31:0] mnt_wr_offset_o,
  input wire logic [31:0] mnt_wr_data_o,
  input wire logic        mnt_resp_valid_i,
  input wire logic        mnt_resp_error_i
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // ------------------------------------------------------------
  // start, write handshake and order
  // ------------------------------------------------------------
  AST_GATE:
    assert property (!busy_o && start_i && !link_ready_i |=> !busy_o) else $error("early start");
  AST_START:
    assert property (!busy_o && start_i && link_ready_i |=> busy_o && mnt_wr_valid_o
      && step_o == 6'h00) else $error("start not taken");
  AST_HOLD:
    assert property (mnt_wr_valid_o && !mnt_wr_ready_i |=> mnt_wr_valid_o
      && $stable(mnt_wr_offset_o) && $stable(mnt_wr_data_o)) else $error("write dropped");
  AST_ONE_OUT:
    assert property (mnt_wr_valid_o && mnt_wr_ready_i |=> !mnt_wr_valid_o) else $error("overlap");
  AST_NEXT:
    assert property (busy_o && !mnt_wr_valid_o && mnt_resp_valid_i && !mnt_resp_error_i
      |=> mnt_wr_valid_o || done_o) else $error("no next write");
  AST_FIRST:
    assert property (mnt_wr_valid_o && step_o == 6'h00 |-> mnt_wr_offset_o == 32'h000132C8
      && mnt_wr_data_o == 32'h7FFF0012) else $error("bad first write");
  AST_LAST:
    assert property (mnt_wr_valid_o && step_o == 6'h22 |-> mnt_wr_offset_o == 32'h000132C8
      && mnt_wr_data_o == 32'h7FFF0002) else $error("bad last write");
  AST_DONE:
    assert property (busy_o && !mnt_wr_valid_o && mnt_resp_valid_i && !mnt_resp_error_i
      && step_o == 6'h22 |=> done_o && !busy_o) else $error("no done");
endmodule // rate_seq_asserts
bind serdes_rate_reconfig_seq rate_seq_asserts u_chk (.*);

/* File: testbench/device_model.sv */
// behavioural device: register file behind the maintenance write link
`timescale 1ns/1ps
module device_model #(
  parameter logic [31:0] MULT_DEFAULT = 32'h00000000
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rstn_i,
  input  wire logic        wr_valid_i,
  output logic             wr_ready_o,
  input  wire logic [31:0] wr_offset_i,
  input  wire logic [31:0] wr_data_i,
  output logic             resp_valid_o,
  output logic             resp_error_o,
  input  wire logic [1:0]  lat_i,
  input  wire logic [7:0]  err_at_i,
  input  wire logic        mute_i
);
  logic [31:0] regs_reg [7];
  logic [1:0]  cnt_reg;
  logic [7:0]  nwr_reg;
  logic        pend_reg;
  always_ff @(posedge clk_sys_i) begin
    wr_ready_o <= 1'b0;
    resp_valid_o <= 1'b0;
    if (!rstn_i) begin
      // ------------------------------------------------------------
      // multiplier is volatile: reset brings the default back
      // ------------------------------------------------------------
      foreach (regs_reg[i]) regs_reg[i] <= (i == 5) ? MULT_DEFAULT : 32'h00000000;
      cnt_reg <= 2'h0;
      nwr_reg <= 8'h00;
      pend_reg <= 1'b0;
      resp_error_o <= 1'b0;
    end else if (pend_reg) begin
      cnt_reg <= cnt_reg + 2'h1;
      if (cnt_reg >= lat_i && !mute_i) begin
        pend_reg <= 1'b0;
        cnt_reg <= 2'h0;
        resp_valid_o <= 1'b1;
        resp_error_o <= (nwr_reg == err_at_i);
        nwr_reg <= nwr_reg + 8'h01;
      end
    end else if (wr_valid_i && wr_ready_o) begin
      regs_reg[3'(wr_offset_i[7:2] - 6'h2C)] <= wr_data_i;
      pend_reg <= 1'b1;
      cnt_reg <= 2'h0;
    end else if (wr_valid_i) begin
      cnt_reg <= cnt_reg + 2'h1;
      wr_ready_o <= (cnt_reg >= lat_i);
    end
  end
endmodule // device_model

/* File: testbench/test_serdes_rate_reconfig_seq.sv */
// self-checking bench for the lane rate reconfiguration host
`timescale 1ns/1ps
module test_serdes_rate_reconfig_seq;
  // ------------------------------------------------------------
  // clock, stimulus and scoreboard
  // ------------------------------------------------------------
  logic        clk_sys_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        start_i = 1'b0;
  logic        link_ready_i = 1'b0;
  logic        busy_o, done_o, error_o, mnt_wr_valid_o, mnt_wr_ready_i;
  logic        mnt_resp_valid_i, mnt_resp_error_i, mute = 1'b0;
  logic [5:0]  step_o;
  logic [31:0] mnt_wr_offset_o, mnt_wr_data_o, rnd = 32'h00000054;
  logic [1:0]  lat = 2'h0;
  logic [7:0]  err_at = 8'hFF;
  logic [63:0] exp_q[$];
  int          bad_count = 0;
  int          compares = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  serdes_rate_reconfig_seq #(.RESP_TIMEOUT(20'h00014)) u_dut (.*);
  device_model u_dev (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wr_valid_i(mnt_wr_valid_o),
    .wr_ready_o(mnt_wr_ready_i), .wr_offset_i(mnt_wr_offset_o), .wr_data_i(mnt_wr_data_o),
    .resp_valid_o(mnt_resp_valid_i), .resp_error_o(mnt_resp_error_i), .lat_i(lat),
    .err_at_i(err_at), .mute_i(mute));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  always @(posedge clk_sys_i) begin
    rnd = xs(rnd);
    lat <= rnd[1:0];
  end
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (e !== g) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  always @(posedge clk_sys_i)
    if (rstn_i && mnt_wr_valid_o && mnt_wr_ready_i)
      chk("write", exp_q.size() ? exp_q.pop_front() : 64'h0, {mnt_wr_offset_o, mnt_wr_data_o});
  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    exp_q.push_back({24'h000132, o, d});
  endtask
  task automatic lanes(input logic [31:0] d);
    for (int i = 0; i < 4; i++) wr(8'hB0 + 8'(4 * i), d);
  endtask
  task automatic push_seq();
    logic [31:0] g[5] = '{32'hCA060045, 32'hCA060005, 32'h4A060005, 32'hCA060005, 32'hCA060085};
    wr(8'hC8, 32'h7FFF0012);
    wr(8'hC0, 32'hCA060084);
    lanes(32'h203CA513);
    lanes(32'h203C2513);
    lanes(32'h200C2513);
    wr(8'hC0, 32'hCA060004);
    wr(8'hC0, 32'hCA060044);
    wr(8'hC4, 32'h002C0545);
    foreach (g[i]) wr(8'hC0, g[i]);
    lanes(32'h203C2513);
    lanes(32'h203CA513);
    lanes(32'h203CE513);
    wr(8'hC8, 32'h7FFF0002);
  endtask
  task automatic run(input string nm, input logic [7:0] ea, input logic ok, input int left);
    int n;
    n = 0;
    push_seq();
    @(posedge clk_sys_i);
    err_at <= ea;
    start_i <= 1'b1;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
    @(negedge clk_sys_i);
    while (done_o !== 1'b1 && error_o !== 1'b1 && n < 3000) begin
      @(negedge clk_sys_i);
      n++;
    end
    chk({nm, " done"}, 64'(ok), 64'(done_o));
    chk({nm, " left"}, 64'(left), 64'(exp_q.size()));
    exp_q.delete();
    $display("test %s finished", nm);
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    start_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    start_i <= 1'b0;
    link_ready_i <= 1'b1;
    @(negedge clk_sys_i);
    chk("idle while link down", 64'h0, 64'(busy_o));
    run("full", 8'hFF, 1'b1, 0);
    chk("lane3", 64'h203CE513, 64'(u_dev.regs_reg[3]));
    chk("global", 64'hCA060085, 64'(u_dev.regs_reg[4]));
    chk("mult", 64'h002C0545, 64'(u_dev.regs_reg[5]));
    chk("mac", 64'h7FFF0002, 64'(u_dev.regs_reg[6]));
    run("again", 8'hFF, 1'b1, 0);
    run("error", u_dev.nwr_reg + 8'h11, 1'b0, 17);
    mute <= 1'b1;
    run("silent", 8'hFF, 1'b0, 34);
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    mute <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(negedge clk_sys_i);
    chk("after reset", 64'h0, 64'({busy_o, done_o, error_o, mnt_wr_valid_o}));
    run("resume", 8'hFF, 1'b1, 0);
    end_sim();
  end
endmodule // test_serdes_rate_reconfig_seq
